/* File: rtl/csccr_pkg.sv */
// constants, register map and types of the color-space control block
// assumes a single pclk domain and an apb master on the register side
// ============================================================
// How it works
// [R1] soft reset clears registers, flushes fifo, drops out valid and in ready
// [R2] control bit 30 set enters reset at once, even mid-frame
// [R3] reset stays while the reset flag stays set
// [R4] after clearing, wait for a frame start before passing data again
// [R5] frame-synced reset waits for frame end, then lasts 32 cycles
// [R6] frame-synced reset with no frame in progress starts at once
// [R7] stalled input keeps a pending frame-synced reset deferred
// [R8] frame size and conversion registers are written into shadow copies
// [R9] shadow copies go active at frame start only when commit flag is set
// [R10] frame start is user sideband bit 0 on an accepted input beat
// [R11] software clears commit flag around multi-register updates
// [R12] every register access moves a full 32-bit word
// [R13] frame is in progress from start beat until last beat of last line
package csccr_pkg;
  // ============================================================
  // register byte offsets
  localparam logic [11:0] CSCCR_CONTROL = 12'h000;
  localparam logic [11:0] CSCCR_STATUS = 12'h004;
  localparam logic [11:0] CSCCR_VERSION = 12'h010;
  localparam logic [11:0] CSCCR_ACTIVE_SIZE = 12'h020;
  localparam logic [11:0] CSCCR_CONV_BASE = 12'h100;
  localparam logic [11:0] CSCCR_CONV_LAST = 12'h130;
  localparam logic [11:0] CSCCR_ACT_SIZE_RD = 12'h040;
  localparam logic [11:0] CSCCR_ACT_CONV_RD = 12'h044;
  localparam int CSCCR_NUM_CONV = 13;
  // ============================================================
  // control fields
  localparam int CSCCR_CTL_ENABLE = 0;
  localparam int CSCCR_CTL_COMMIT = 1;
  localparam int CSCCR_CTL_AUTO_RST = 31;
  localparam int CSCCR_CTL_RESET = 30;
  // status fields
  localparam int CSCCR_ST_IN_FRAME = 0;
  localparam int CSCCR_ST_IN_RESET = 1;
  localparam int CSCCR_ST_SYNCED = 2;
  localparam int CSCCR_ST_AUTO_PEND = 3;
  // ============================================================
  // reset values
  localparam logic [31:0] CSCCR_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] CSCCR_SIZE_RST = 32'h0000_0000;
  localparam logic [31:0] CSCCR_CONV_RST = 32'h0000_0000;
  // version value is arbitrary
  localparam logic [31:0] CSCCR_VERSION_VAL = 32'h0001_0000;
  // ============================================================
  // timing
  localparam int CSCCR_AUTO_RST_CYC = 32;
  // ============================================================
  typedef enum logic [2:0] {
    CSCCR_RUN = 3'b001,
    CSCCR_WAIT_END = 3'b010,
    CSCCR_HOLD = 3'b100
  } csccr_auto_t;
endpackage

/* File: rtl/csccr_fifo.sv */
// small first-word-fall-through fifo with synchronous flush
// assumes one clock; flush overrides both sides
`timescale 1ns/100ps
module csccr_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: rtl/csccr_frame_track.sv */
// frame tracker on the accepted input beats
// assumes tlast marks end of line and lines_per_frame is nonzero
`timescale 1ns/100ps
module csccr_frame_track (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic beat,
  input wire logic sof,
  input wire logic eol,
  input wire logic [15:0] lines,
  output logic in_frame,
  output logic frame_end
);
  logic [15:0] line_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame <= 1'b0;
      line_cnt <= 16'h0000;
      frame_end <= 1'b0;
    end else if (clear) begin
      in_frame <= 1'b0;
      line_cnt <= 16'h0000;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (beat && sof) begin
        in_frame <= !(eol && lines <= 16'h0001); // R13
        line_cnt <= eol ? 16'h0001 : 16'h0000;
        frame_end <= eol && lines <= 16'h0001;
      end else if (beat && in_frame && eol) begin
        if (line_cnt + 16'h0001 >= lines) begin
          in_frame <= 1'b0; // R13
          frame_end <= 1'b1;
          line_cnt <= 16'h0000;
        end else begin
          line_cnt <= line_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

/* File: rtl/csccr_ctrl.sv */
// control side of the color-space converter: apb registers, resets,
// shadow/active register sets and the gated stream path
// assumes apb master per amba apb; stream cores on tvalid/tready
`timescale 1ns/100ps
module csccr_ctrl
  import csccr_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DATA_W-1:0] in_tdata,
  input wire logic in_tvalid,
  input wire logic in_tlast,
  input wire logic in_frame_start_marker,
  output logic in_tready,
  output logic [DATA_W-1:0] out_tdata,
  output logic out_tvalid,
  output logic out_tlast,
  output logic out_tuser,
  input wire logic out_tready,
  output logic [31:0] active_size,
  output logic [32*CSCCR_NUM_CONV-1:0] active_conv,
  output logic core_in_reset
);
  // ============================================================
  // signals
  logic [31:0] control;
  logic [31:0] shadow_size;
  logic [31:0] shadow_conv [CSCCR_NUM_CONV];
  csccr_auto_t auto_st;
  csccr_auto_t next_auto_st;
  logic [5:0] hold_cnt;
  logic synced;
  logic soft_rst;
  logic auto_rst;
  logic rst_any;
  logic in_frame;
  logic frame_end;
  logic in_beat;
  logic in_sof;
  logic wr_acc;
  logic shadow_commit_enable;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W+1:0] fifo_out_data;
  logic pass;

  function automatic logic is_conv(input logic [11:0] a);
    return a >= CSCCR_CONV_BASE && a <= CSCCR_CONV_LAST && a[1:0] == 2'b00;
  endfunction

  function automatic int conv_idx(input logic [11:0] a);
    return int'((a - CSCCR_CONV_BASE) >> 2);
  endfunction

  // ============================================================
  // apb access; every access is a whole word, no byte lanes
  assign wr_acc = psel && penable && pwrite && pready; // R12
  assign shadow_commit_enable = control[CSCCR_CTL_COMMIT];
  assign soft_rst = control[CSCCR_CTL_RESET];
  assign auto_rst = (auto_st == CSCCR_HOLD);
  assign rst_any = soft_rst || auto_rst;
  assign in_beat = in_tvalid && in_tready;
  assign in_sof = in_beat && in_frame_start_marker; // R10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr[1:0] != 2'b00) begin
        pslverr <= 1'b1;
      end else if (!pwrite) begin
        if (paddr == CSCCR_CONTROL) begin
          prdata <= control; // R12
        end else if (paddr == CSCCR_STATUS) begin
          prdata <= {28'h0000000, auto_st != CSCCR_RUN, synced,
                     rst_any, in_frame};
        end else if (paddr == CSCCR_VERSION) begin
          prdata <= CSCCR_VERSION_VAL;
        end else if (paddr == CSCCR_ACTIVE_SIZE) begin
          prdata <= shadow_size;
        end else if (paddr == CSCCR_ACT_SIZE_RD) begin
          prdata <= active_size;
        end else if (is_conv(paddr)) begin
          prdata <= shadow_conv[conv_idx(paddr)];
        end else begin
          pslverr <= 1'b1;
        end
      end else if (!(paddr == CSCCR_CONTROL
                     || paddr == CSCCR_ACTIVE_SIZE || is_conv(paddr))) begin
        pslverr <= 1'b1;
      end
    end
  end

  // ============================================================
  // control register; reset bit survives only its own clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CSCCR_CONTROL_RST;
    end else if (wr_acc && paddr == CSCCR_CONTROL) begin
      control <= pwdata; // R2 R3
      control[CSCCR_CTL_AUTO_RST] <= 1'b0;
    end else if (rst_any) begin
      control <= CSCCR_CONTROL_RST; // R1
      control[CSCCR_CTL_RESET] <= soft_rst; // R3
    end
  end

  // ============================================================
  // shadow registers, written at once by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_size <= CSCCR_SIZE_RST;
      for (int i = 0; i < CSCCR_NUM_CONV; i++) begin
        shadow_conv[i] <= CSCCR_CONV_RST;
      end
    end else if (rst_any) begin
      shadow_size <= CSCCR_SIZE_RST; // R1
      for (int i = 0; i < CSCCR_NUM_CONV; i++) begin
        shadow_conv[i] <= CSCCR_CONV_RST;
      end
    end else if (wr_acc) begin
      if (paddr == CSCCR_ACTIVE_SIZE) begin
        shadow_size <= pwdata; // R8
      end else if (is_conv(paddr)) begin
        shadow_conv[conv_idx(paddr)] <= pwdata; // R8
      end
    end
  end

  // ============================================================
  // active set, committed at start of frame when commit flag is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_size <= CSCCR_SIZE_RST;
      active_conv <= '0;
    end else if (rst_any) begin
      active_size <= CSCCR_SIZE_RST;
      active_conv <= '0;
    end else if (in_sof && shadow_commit_enable) begin
      active_size <= shadow_size; // R9
      for (int i = 0; i < CSCCR_NUM_CONV; i++) begin
        active_conv[32*i +: 32] <= shadow_conv[i]; // R9
      end
    end
  end

  // ============================================================
  // frame tracking
  csccr_frame_track u_track (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rst_any),
    .beat(in_beat),
    .sof(in_frame_start_marker),
    .eol(in_tlast),
    .lines(active_size[31:16]),
    .in_frame(in_frame),
    .frame_end(frame_end)
  );

  // ============================================================
  // frame-synced reset sequencer
  always_comb begin
    next_auto_st = auto_st;
    case (auto_st)
      CSCCR_RUN: begin
        if (wr_acc && paddr == CSCCR_CONTROL
            && pwdata[CSCCR_CTL_AUTO_RST]) begin
          next_auto_st = in_frame ? CSCCR_WAIT_END : CSCCR_HOLD; // R5 R6
        end
      end
      CSCCR_WAIT_END: begin
        if (frame_end || in_sof || soft_rst) begin
          next_auto_st = CSCCR_HOLD; // R7
        end
      end
      CSCCR_HOLD: begin
        if (hold_cnt == 6'(CSCCR_AUTO_RST_CYC - 1)) begin
          next_auto_st = CSCCR_RUN; // R5
        end
      end
      default: next_auto_st = CSCCR_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_st <= CSCCR_RUN;
    end else begin
      auto_st <= next_auto_st;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 6'h00;
    end else if (auto_st == CSCCR_HOLD) begin
      hold_cnt <= hold_cnt + 6'h01; // R5
    end else begin
      hold_cnt <= 6'h00;
    end
  end

  // ============================================================
  // resync: after reset, drop beats until a frame start arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synced <= 1'b0;
    end else if (rst_any) begin
      synced <= 1'b0; // R4
    end else if (in_sof) begin
      synced <= 1'b1; // R4
    end
  end

  // ============================================================
  // stream path through the fifo
  assign pass = synced || in_frame_start_marker;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_tready <= 1'b0;
    end else begin
      // ready lags a cycle: pause after each push so the fifo never overruns
      in_tready <= !rst_any && fifo_in_ready && !(in_beat && pass); // R1
    end
  end

  csccr_fifo #(
    .WIDTH(DATA_W + 2),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rst_any), // R1
    .in_valid(in_beat && pass),
    .in_ready(fifo_in_ready),
    .in_data({in_frame_start_marker, in_tlast, in_tdata}),
    .out_valid(fifo_out_valid),
    .out_ready(!out_tvalid || out_tready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_tvalid <= 1'b0;
      out_tdata <= '0;
      out_tlast <= 1'b0;
      out_tuser <= 1'b0;
    end else if (rst_any) begin
      out_tvalid <= 1'b0; // R1
    end else if (!out_tvalid || out_tready) begin
      out_tvalid <= fifo_out_valid;
      out_tdata <= fifo_out_data[DATA_W-1:0];
      out_tlast <= fifo_out_data[DATA_W];
      out_tuser <= fifo_out_data[DATA_W+1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_in_reset <= 1'b0;
    end else begin
      core_in_reset <= rst_any;
    end
  end

  // ============================================================
  // checks
  logic [6:0] hold_seen;

  // independent count of cycles spent in auto reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_seen <= 7'h00;
    end else if (auto_rst) begin
      hold_seen <= hold_seen + 7'h01;
    end else begin
      hold_seen <= 7'h00;
    end
  end

  a_hold_len: assert property (@(posedge pclk) disable iff (!presetn) // R5
    $fell(auto_rst) |-> hold_seen == 7'(CSCCR_AUTO_RST_CYC))
    else $error("auto reset length wrong");
  a_idle_start: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (auto_st == CSCCR_RUN && !in_frame && wr_acc && paddr == CSCCR_CONTROL
     && pwdata[CSCCR_CTL_AUTO_RST]) |=> auto_rst)
    else $error("idle auto reset not immediate");
  a_defer_busy: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (auto_st == CSCCR_WAIT_END && !frame_end && !in_sof && !soft_rst)
    |=> !auto_rst)
    else $error("auto reset not deferred");
  a_soft_hold: assert property (@(posedge pclk) disable iff (!presetn) // R1
    soft_rst |=> (!in_tready && !out_tvalid))
    else $error("stream not held in reset");
  a_soft_stays: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (soft_rst && !(wr_acc && paddr == CSCCR_CONTROL)) |=> soft_rst)
    else $error("reset flag dropped by itself");
  a_soft_enter: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_acc && paddr == CSCCR_CONTROL && pwdata[CSCCR_CTL_RESET])
    |=> rst_any ##1 core_in_reset)
    else $error("reset not immediate");
  a_commit_keep: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (in_sof && !shadow_commit_enable && !rst_any) |=> $stable(active_size))
    else $error("active set changed without commit");
  a_commit_take: assert property (@(posedge pclk) // R9 R10
    disable iff (!presetn) (in_sof && shadow_commit_enable && !rst_any)
    |=> active_size == $past(shadow_size))
    else $error("commit missed");
  a_shadow_wr: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (wr_acc && paddr == CSCCR_ACTIVE_SIZE && !rst_any)
    |=> shadow_size == $past(pwdata))
    else $error("shadow write lost");
  a_resync: assert property (@(posedge pclk) disable iff (!presetn) // R4
    $fell(rst_any) |-> !synced)
    else $error("no resync after reset");
  c_auto_idle: cover property (@(posedge pclk) disable iff (!presetn)
    auto_st == CSCCR_RUN ##1 auto_st == CSCCR_HOLD);
  c_auto_wait: cover property (@(posedge pclk) disable iff (!presetn)
    auto_st == CSCCR_WAIT_END ##[1:1000] auto_st == CSCCR_HOLD);
  c_commit: cover property (@(posedge pclk) disable iff (!presetn)
    in_sof && shadow_commit_enable);
  c_soft: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(soft_rst));
endmodule

/* File: sim/csccr_stream_model.sv */
// stream source and sink standing around the control block
// assumes go is pulsed only while busy is low
`timescale 1ns/100ps
module csccr_stream_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic pause,
  input wire logic hold_sink,
  input wire logic [7:0] beats,
  input wire logic in_tready,
  output logic [23:0] in_tdata,
  output logic in_tvalid,
  output logic in_tlast,
  output logic in_frame_start_marker,
  input wire logic out_tvalid,
  output logic out_tready,
  output logic busy,
  output logic [15:0] out_beats
);
  logic [7:0] sent;
  logic flip;
  logic fire;
  logic last_fire;
  assign fire = in_tvalid & in_tready;
  assign last_fire = fire && sent == beats - 8'h01;
  // idle lines wander, only accepted beats mean anything
  assign in_tdata = in_tvalid ? {16'h0000, sent} : {24{flip}};
  assign in_frame_start_marker = in_tvalid ? sent == 8'h00 : flip;
  assign in_tlast = in_tvalid ? sent[1:0] == 2'h3 : ~flip;
  // =========
  // source: valid holds until taken, pause stalls mid-frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent <= 8'h00;
      busy <= 1'b0;
      in_tvalid <= 1'b0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      if (go) begin
        busy <= 1'b1;
        sent <= 8'h00;
      end else begin
        if (fire) sent <= sent + 8'h01;
        if (last_fire) busy <= 1'b0;
      end
      if (!in_tvalid || fire) begin
        in_tvalid <= (go || (busy && !last_fire)) && !pause;
      end
    end
  end
  // =========
  // sink
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_tready <= 1'b0;
      out_beats <= 16'h0000;
    end else begin
      out_tready <= !hold_sink;
      if (out_tvalid && out_tready) out_beats <= out_beats + 16'h0001;
    end
  end
endmodule

/* File: sim/csccr_ctrl_tb_top.sv */
// self-checking bench for the control block
// assumes apb answers with pready, stream model on the data side
`timescale 1ns/100ps
module csccr_ctrl_tb_top
  import csccr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, active_size;
  logic [23:0] in_tdata, out_tdata;
  logic in_tvalid, in_tlast, in_frame_start_marker, in_tready;
  logic out_tvalid, out_tlast, out_tuser, out_tready, core_in_reset;
  logic [32*CSCCR_NUM_CONV-1:0] active_conv;
  logic go, pause, hold_sink, busy;
  logic [7:0] beats;
  logic [15:0] out_beats;
  int failures;
  int check_count;
  csccr_ctrl #(.DATA_W(24), .FIFO_DEPTH(4)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_tdata(in_tdata), .in_tvalid(in_tvalid),
    .in_tlast(in_tlast), .in_frame_start_marker(in_frame_start_marker),
    .in_tready(in_tready), .out_tdata(out_tdata), .out_tvalid(out_tvalid),
    .out_tlast(out_tlast), .out_tuser(out_tuser), .out_tready(out_tready),
    .active_size(active_size), .active_conv(active_conv),
    .core_in_reset(core_in_reset));
  csccr_stream_model model (.pclk(pclk), .presetn(presetn), .go(go),
    .pause(pause), .hold_sink(hold_sink), .beats(beats),
    .in_tready(in_tready), .in_tdata(in_tdata), .in_tvalid(in_tvalid),
    .in_tlast(in_tlast), .in_frame_start_marker(in_frame_start_marker),
    .out_tvalid(out_tvalid), .out_tready(out_tready), .busy(busy),
    .out_beats(out_beats));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // =========
  // helpers
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bit_chk(input string what, input logic e, input logic g);
    check(what, {31'h0, e}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(what, e, rd);
  endtask
  task automatic start(input logic [7:0] n);
    @(posedge pclk);
    beats <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic finish;
    while (busy === 1'b1) begin
      @(posedge pclk);
    end
    repeat (12) @(posedge pclk);
  endtask
  task automatic auto_len(output int w, output int h);
    w = 0;
    h = 0;
    while (core_in_reset !== 1'b1 && w < 200) begin
      w++;
      @(posedge pclk);
    end
    while (core_in_reset === 1'b1 && h < 200) begin
      h++;
      @(posedge pclk);
    end
  endtask
  // =========
  // scenarios
  task automatic t_regs;
    rchk("control", CSCCR_CONTROL, CSCCR_CONTROL_RST);
    rchk("version", CSCCR_VERSION, CSCCR_VERSION_VAL);
    wr(CSCCR_CONV_LAST, 32'ha5c3_3c5a);
    rchk("conv word", CSCCR_CONV_LAST, 32'ha5c3_3c5a);
    wr(CSCCR_ACTIVE_SIZE, 32'h0002_0004);
    check("active early", 32'h0, active_size);
    apb(1'b0, 12'h008, 32'h0);
    bit_chk("unmapped", 1'b1, err);
    $display("test regs done");
  endtask
  task automatic t_commit;
    logic [15:0] base;
    wr(CSCCR_CONTROL, 32'h1);
    start(8'd4);
    finish;
    check("size kept", 32'h0, active_size);
    wr(CSCCR_CONTROL, 32'h3);
    hold_sink <= 1'b1;
    base = out_beats;
    start(8'd8);
    repeat (30) @(posedge pclk);
    bit_chk("fifo full", 1'b0, in_tready);
    check("sink held", {16'h0, base}, {16'h0, out_beats});
    check("size commit", 32'h0002_0004, active_size);
    check("conv commit", 32'ha5c3_3c5a, active_conv[384 +: 32]);
    apb(1'b0, CSCCR_STATUS, 32'h0);
    bit_chk("in frame", 1'b1, rd[CSCCR_ST_IN_FRAME]);
    bit_chk("first user", 1'b1, out_tuser);
    check("first data", 32'h0, {8'h0, out_tdata});
    repeat (3) begin
      hold_sink <= 1'b0;
      @(posedge pclk);
      hold_sink <= 1'b1;
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    check("fourth data", 32'h3, {8'h0, out_tdata});
    bit_chk("line end", 1'b1, out_tlast);
    bit_chk("mid user", 1'b0, out_tuser);
    hold_sink <= 1'b0;
    finish;
    check("drained", {16'h0, base + 16'd8}, {16'h0, out_beats});
    apb(1'b0, CSCCR_STATUS, 32'h0);
    bit_chk("frame over", 1'b0, rd[CSCCR_ST_IN_FRAME]);
    $display("test commit done");
  endtask
  task automatic t_soft;
    logic [15:0] base;
    start(8'd8);
    repeat (3) @(posedge pclk);
    pause <= 1'b1;
    wr(CSCCR_CONTROL, 32'h4000_0003);
    repeat (2) @(posedge pclk);
    bit_chk("in reset", 1'b1, core_in_reset);
    bit_chk("ready low", 1'b0, in_tready);
    bit_chk("valid low", 1'b0, out_tvalid);
    check("active cleared", 32'h0, active_size);
    rchk("control", CSCCR_CONTROL, 32'h4000_0000);
    rchk("shadow", CSCCR_ACTIVE_SIZE, 32'h0);
    pause <= 1'b0;
    repeat (40) @(posedge pclk);
    bit_chk("held", 1'b1, core_in_reset);
    base = out_beats;
    wr(CSCCR_CONTROL, 32'h1);
    finish;
    bit_chk("released", 1'b0, core_in_reset);
    check("tail dropped", {16'h0, base}, {16'h0, out_beats});
    start(8'd4);
    finish;
    check("resynced", {16'h0, base + 16'd4}, {16'h0, out_beats});
    $display("test soft reset done");
  endtask
  task automatic t_auto_idle;
    int w;
    int h;
    logic [15:0] base;
    wr(CSCCR_CONTROL, 32'h8000_0001);
    auto_len(w, h);
    bit_chk("prompt", 1'b1, w <= 4);
    check("auto length", CSCCR_AUTO_RST_CYC, h);
    rchk("control", CSCCR_CONTROL, 32'h0);
    wr(CSCCR_CONTROL, 32'h1);
    base = out_beats;
    start(8'd4);
    finish;
    check("after auto", {16'h0, base + 16'd4}, {16'h0, out_beats});
    $display("test idle auto reset done");
  endtask
  task automatic t_auto_busy;
    int w;
    int h;
    logic seen;
    seen = 1'b0;
    start(8'd4);
    pause <= 1'b1;
    apb(1'b0, CSCCR_STATUS, 32'h0);
    bit_chk("stalled frame", 1'b1, rd[CSCCR_ST_IN_FRAME]);
    wr(CSCCR_CONTROL, 32'h8000_0001);
    repeat (60) begin
      @(posedge pclk);
      if (core_in_reset === 1'b1) seen = 1'b1;
    end
    bit_chk("deferred", 1'b0, seen);
    pause <= 1'b0;
    auto_len(w, h);
    bit_chk("after frame", 1'b1, w <= 20);
    check("auto length", CSCCR_AUTO_RST_CYC, h);
    $display("test busy auto reset done");
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, pause, hold_sink} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    beats = 8'h04;
    failures = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_commit;
    t_soft;
    t_auto_idle;
    t_auto_busy;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report;
  end
endmodule
